// File: hdl/scxd_byte_mover.sv
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ns
module scxd_byte_mover
  import scxd_pkg::*;
(
  // apb
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // peripheral requests, one per channel
  input  wire logic [scxd_pkg::NCH-1:0] function_select_req,
  // processor holds ram / register space this cycle
  input  wire logic                cpu_busy,
  // data ram port
  output logic      [11:0]         ram_addr,
  output logic                     ram_rd,
  output logic                     ram_wr,
  output logic      [7:0]          ram_wdata,
  input  wire logic [7:0]          ram_rdata,
  // peripheral register port
  output logic      [2:0]          reg_func,
  output logic                     reg_wr,
  output logic      [7:0]          reg_wdata,
  output logic                     reg_rd,
  input  wire logic [7:0]          reg_rdata,
  // flags
  output logic      [scxd_pkg::NCH-1:0] full_flags,
  output logic      [scxd_pkg::NCH-1:0] half_flags
);
  import scxd_pkg::*;

  // ***************************************************
  // per-channel configuration
  // ***************************************************
  logic [2:0]        sel_q;
  logic [CTL_W-1:0]  ctl_q  [NCH];
  logic              wrap_q [NCH];
  logic [BASE_W-1:0] base_q [NCH];
  logic [OFS_W-1:0]  ofs_q  [NCH];
  logic [OFS_W-1:0]  size_q [NCH];
  logic [NCH-1:0]    en_q, busy_q, full_q, half_q;

  logic apb_wr, apb_rd, sel_ok, sel_busy;
  assign apb_wr   = psel & penable & pwrite;
  assign apb_rd   = psel & penable & ~pwrite;
  assign sel_ok   = (sel_q < 3'(NCH));
  assign sel_busy = sel_ok & busy_q[sel_q];

  // ***************************************************
  // engine state
  // ***************************************************
  logic [2:0] ch_q;     // channel in flight
  logic       act_q;    // engine owns channel ch_q
  logic       rd2_q;    // ram read issued, register write pending
  logic       go;
  logic       step;      // one byte completes this cycle
  logic       stop_here; // current byte raises a flag, channel must pause
  logic [2:0] win;
  logic [NCH-1:0] want;

  // eligible: enabled, not stalled, flags clear, requested or already busy
  always_comb begin
    for (int i = 0; i < NCH; i++)
      want[i] = en_q[i] & ~ctl_q[i][CTL_STALL] & ~full_q[i] & ~half_q[i]
                & (function_select_req[i] | busy_q[i])
                & ~(stop_here && ch_q == 3'(i));
    win = 3'h0;
    for (int i = NCH - 1; i >= 0; i--)
      if (want[i])
        win = 3'(i);
  end
  // processor always pre-empts the engine
  assign go = ~cpu_busy & (|want) & ~rd2_q;

  logic [OFS_W-1:0] cur_ofs, nxt_ofs, half_pt;
  logic             last, to_ram, half_hit;
  assign cur_ofs = ofs_q[ch_q];
  assign to_ram  = (ctl_q[ch_q][2:0] == SCXD_ENC_TO_RAM) |
                   (ctl_q[ch_q][2:0] == SCXD_SPI_TO_RAM);
  assign last    = (cur_ofs == size_q[ch_q] - 10'h001);
  assign half_pt = (size_q[ch_q] >> 1) + {9'h000, size_q[ch_q][0]};
  assign half_hit = (cur_ofs + 10'h001 == half_pt);
  assign nxt_ofs = (last & wrap_q[ch_q]) ? 10'h000
                 : cur_ofs + 10'h001;

  // ***************************************************
  // transfer sequencing
  // ***************************************************
  assign step = act_q & ~cpu_busy & (to_ram | rd2_q);
  // flags land one edge late, so the byte that sets one stops re-arbitration
  assign stop_here = step & (last | half_hit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 1'b0;
      ch_q  <= 3'h0;
      rd2_q <= 1'b0;
    end else if (!act_q || step) begin
      // arbitration only between bytes
      act_q <= go;
      ch_q  <= go ? win : ch_q;
      rd2_q <= 1'b0;
    end else if (!cpu_busy && !to_ram) begin
      rd2_q <= 1'b1;
    end
  end

  // ***************************************************
  // ram and register ports
  // ***************************************************
  // ram data stands one cycle only; keep it in case the processor delays
  logic       rdv_q;     // ram read data valid this cycle
  logic       wr_pend_q; // register write due next edge
  logic [7:0] data_q;    // held ram read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdv_q     <= 1'b0;
      wr_pend_q <= 1'b0;
      data_q    <= 8'h00;
    end else begin
      rdv_q     <= ram_rd;
      wr_pend_q <= step & ~to_ram;
      data_q    <= rdv_q ? ram_rdata : data_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_addr  <= 12'h000;
      ram_rd    <= 1'b0;
      ram_wr    <= 1'b0;
      ram_wdata <= 8'h00;
      reg_func  <= 3'h0;
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_wdata <= 8'h00;
    end else begin
      ram_addr  <= base_q[ch_q] + {2'b00, cur_ofs};
      ram_rd    <= act_q & ~cpu_busy & ~to_ram & ~rd2_q;
      ram_wr    <= step & to_ram;
      ram_wdata <= reg_rdata;
      reg_rd    <= step & to_ram;
      reg_func  <= ctl_q[ch_q][2:0];
      reg_wr    <= wr_pend_q;
      reg_wdata <= rdv_q ? ram_rdata : data_q;
    end
  end

  // ***************************************************
  // registers and channel counters
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q  <= 3'h0;
      en_q   <= '0;
      busy_q <= '0;
      full_q <= '0;
      half_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        ctl_q[i]  <= CTL_RESET;
        wrap_q[i] <= 1'b0;
        base_q[i] <= '0;
        ofs_q[i]  <= '0;
        size_q[i] <= '0;
      end
    end else begin
      if (apb_wr) begin
        unique case (paddr)
          ADDR_SELECT: sel_q <= pwdata[2:0];
          ADDR_CONTROL: if (sel_ok) ctl_q[sel_q] <= pwdata[7:0];
          ADDR_WRAP: if (sel_ok) wrap_q[sel_q] <= pwdata[0];
          ADDR_BASE: if (sel_ok && !sel_busy)
            base_q[sel_q] <= pwdata[11:0];
          ADDR_OFFSET: if (sel_ok && !sel_busy)
            ofs_q[sel_q] <= pwdata[9:0];
          ADDR_SIZE: if (sel_ok && !sel_busy)
            size_q[sel_q] <= pwdata[9:0];
          ADDR_ENABLES: en_q <= pwdata[NCH-1:0];
          ADDR_ACTIVITY: busy_q <= busy_q | pwdata[NCH-1:0];
          ADDR_FULL: full_q <= full_q & pwdata[NCH-1:0];
          ADDR_HALF: half_q <= half_q & pwdata[NCH-1:0];
          default: ;
        endcase
      end
      if (act_q && !(apb_wr && paddr == ADDR_ACTIVITY))
        busy_q[ch_q] <= 1'b1;
      if (step) begin
        ofs_q[ch_q] <= nxt_ofs;
        // set wins over a software clear in the same cycle
        if (last) begin
          full_q[ch_q] <= 1'b1;
          busy_q[ch_q] <= 1'b0;
        end
        if (half_hit)
          half_q[ch_q] <= 1'b1;
        if (!function_select_req[ch_q] && !last)
          busy_q[ch_q] <= 1'b0;
      end
    end
  end

  // ***************************************************
  // apb read and outputs
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ADDR_SELECT:   prdata <= {29'h0, sel_q};
          ADDR_CONTROL:  prdata <= sel_ok ? {24'h0, ctl_q[sel_q]} : 32'h0;
          ADDR_WRAP:     prdata <= sel_ok ? {31'h0, wrap_q[sel_q]} : 32'h0;
          ADDR_BASE:     prdata <= sel_ok ? {20'h0, base_q[sel_q]} : 32'h0;
          ADDR_OFFSET:   prdata <= sel_ok ? {22'h0, ofs_q[sel_q]} : 32'h0;
          ADDR_SIZE:     prdata <= sel_ok ? {22'h0, size_q[sel_q]} : 32'h0;
          ADDR_ENABLES:  prdata <= {25'h0, en_q};
          ADDR_ACTIVITY: prdata <= {25'h0, busy_q};
          ADDR_FULL:     prdata <= {25'h0, full_q};
          ADDR_HALF:     prdata <= {25'h0, half_q};
          default:       prdata <= 32'h0;
        endcase
      end
    end
  end
  assign pslverr    = 1'b0;
  assign full_flags = full_q;
  assign half_flags = half_q;

  // ***************************************************
  // checks
  // ***************************************************
  a_stall_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    (!act_q && go) |-> !ctl_q[win][CTL_STALL])
    else $error("stalled channel started");
  a_full_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    (!act_q && go) |-> !full_q[win] && en_q[win])
    else $error("flagged or disabled channel started");
  a_write_two: assert property (@(posedge pclk) disable iff (!presetn)
    (step && !to_ram) |-> ##2 reg_wr)
    else $error("register write missing");
  a_cpu_first: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_busy |-> !step)
    else $error("engine moved while processor busy");
  a_full_set: assert property (@(posedge pclk) disable iff (!presetn)
    (step && last) |=> full_q[$past(ch_q)])
    else $error("full flag not set");
  a_ofs_step: assert property (@(posedge pclk) disable iff (!presetn)
    (step && !last) |=> ofs_q[$past(ch_q)] == $past(cur_ofs) + 10'h001)
    else $error("offset did not advance");
  a_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (step && last && wrap_q[ch_q]) |=> ofs_q[$past(ch_q)] == 10'h000)
    else $error("offset did not wrap");
  a_prio_low: assert property (@(posedge pclk) disable iff (!presetn)
    (!act_q && go && want[0]) |=> ch_q == 3'h0)
    else $error("channel 0 lost arbitration");
endmodule // scxd_byte_mover

// File: hdl/scxd_pkg.sv
package scxd_pkg;
  // ***************************************************
  // register offsets (byte addresses, one word each)
  // ***************************************************
  localparam logic [7:0] ADDR_SELECT   = 8'h00;
  localparam logic [7:0] ADDR_CONTROL  = 8'h04;
  localparam logic [7:0] ADDR_WRAP     = 8'h08;
  localparam logic [7:0] ADDR_BASE     = 8'h0c;
  localparam logic [7:0] ADDR_OFFSET   = 8'h10;
  localparam logic [7:0] ADDR_SIZE     = 8'h14;
  localparam logic [7:0] ADDR_ENABLES  = 8'h18;
  localparam logic [7:0] ADDR_ACTIVITY = 8'h1c;
  localparam logic [7:0] ADDR_FULL     = 8'h20;
  localparam logic [7:0] ADDR_HALF     = 8'h24;
  // ***************************************************
  // channel control fields
  // ***************************************************
  localparam int CTL_FUNC_LSB  = 0;
  localparam int CTL_ENDIAN    = 4;
  localparam int CTL_STALL     = 5;
  localparam int CTL_HALF_IE   = 6;
  localparam int CTL_FULL_IE   = 7;
  localparam int CTL_W         = 8;
  localparam int BASE_W        = 12;
  localparam int OFS_W         = 10;
  localparam int NCH           = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // ***************************************************
  // transfer functions
  // ***************************************************
  typedef enum logic [2:0] {
    SCXD_RAM_TO_ENC, SCXD_ENC_TO_RAM, SCXD_RAM_TO_CRC, SCXD_RAM_TO_SPI,
    SCXD_SPI_TO_RAM, SCXD_RAM_TO_KEY, SCXD_RAM_TO_BLK, SCXD_RAM_TO_XOR
  } scxd_func_t;
endpackage

// File: test/scxd_far_end.sv
`timescale 1ns/1ns
// ****
// ram and peripheral registers
// ****
module scxd_far_end (
  input  wire logic        pclk,
  // ram side
  input  wire logic [11:0] ram_addr,
  input  wire logic        ram_rd,
  input  wire logic        ram_wr,
  input  wire logic [7:0]  ram_wdata,
  output logic      [7:0]  ram_rdata = 8'h00,
  // register side
  input  wire logic [2:0]  reg_func,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata
);
  logic [7:0]  rcnt_q = 8'h00;
  logic [19:0] wlog[$];
  logic [10:0] glog[$];
  always @(posedge pclk) begin
    // read data lives one cycle only, then turns over
    ram_rdata <= ram_rd ? (ram_addr[7:0] ^ 8'h5a) : ~ram_rdata;
    if (ram_wr) wlog.push_back({ram_addr, ram_wdata});
    if (reg_wr) glog.push_back({reg_func, reg_wdata});
    if (reg_rd) rcnt_q <= rcnt_q + 8'h01;
  end
  // a pop still in flight already moves the head on
  assign reg_rdata = 8'hc3 ^ (rcnt_q + {7'h00, reg_rd});
endmodule // scxd_far_end

// File: test/scxd_byte_mover_tb.sv
`timescale 1ns/1ns
module scxd_byte_mover_tb;
  import scxd_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, cpu_busy = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, ram_rd, ram_wr, reg_wr, reg_rd;
  logic [6:0]  function_select_req = 7'h00, full_flags, half_flags;
  logic [11:0] ram_addr;
  logic [7:0]  ram_wdata, ram_rdata, reg_wdata, reg_rdata;
  logic [2:0]  reg_func;
  int          miscompares = 0, compares = 0, cyc = 0, tcnt = 0, f, a;
  scxd_byte_mover dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr(), .function_select_req, .cpu_busy,
    .ram_addr, .ram_rd, .ram_wr, .ram_wdata, .ram_rdata, .reg_func,
    .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .full_flags, .half_flags);
  scxd_far_end far (.pclk, .ram_addr, .ram_rd, .ram_wr, .ram_wdata,
    .ram_rdata, .reg_func, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input int ad, input int d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= 8'(ad);
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    // iff sees pready before this edge's updates land
    @(posedge pclk iff pready === 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input int ad, input int exp);
    apb(1'b0, ad, 0);
    chk(rd, 32'(exp));
  endtask
  task automatic wait_flag(input int ch, input bit full);
    for (int k = 0; k < 300; k++) begin
      if ((full ? full_flags[ch] : half_flags[ch]) === 1'b1) break;
      @(posedge pclk);
    end
  endtask
  task automatic cfg(input int ch, input int ctl, input int size);
    far.wlog.delete();
    far.glog.delete();
    apb(1, ADDR_SELECT, ch);
    apb(1, ADDR_CONTROL, ctl);
    apb(1, ADDR_SIZE, size);
    apb(1, ADDR_OFFSET, 0);
  endtask
  task automatic run(input int ch, input int fn, input int base, input int sz);
    int hp;
    bit rdir;
    hp = sz / 2 + sz % 2;
    rdir = (fn == 1 || fn == 4);
    cfg(ch, fn, sz);
    apb(1, ADDR_WRAP, fn == 5);
    apb(1, ADDR_BASE, base);
    apb(1, ADDR_ENABLES, 1 << ch);
    function_select_req <= 7'(1 << ch);
    wait_flag(ch, 0);
    repeat (10) @(posedge pclk);
    chk(far.wlog.size() + far.glog.size(), hp);
    rchk(ADDR_OFFSET, hp);
    apb(1, ADDR_HALF, 0);
    wait_flag(ch, 1);
    function_select_req <= 7'h00;
    repeat (10) @(posedge pclk);
    chk(full_flags[ch], 1);
    chk(far.wlog.size() + far.glog.size(), sz);
    for (int i = 0; i < sz; i++)
      if (rdir) chk(far.wlog[i], {12'(base + i), 8'(8'hc3 ^ (tcnt + i))});
      else chk(far.glog[i], {3'(fn), 8'(8'h5a ^ (base + i))});
    if (rdir) tcnt += sz;
    if (fn == 5) rchk(ADDR_OFFSET, 0);
    apb(1, ADDR_FULL, 0);
    apb(1, ADDR_HALF, 0);
    $display("test function %0d done", fn);
  endtask
  task tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****
  // clock, contention, timeout
  // ****
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    cpu_busy <= ($urandom % 4) == 0;
    if (cyc == 30000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'h4260));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (a = 0; a <= ADDR_HALF; a += 4) rchk(a, 0);
    rchk(8'h3c, 0);
    $display("test reset done");
    for (f = 0; f < 8; f++) run($urandom % 7, f, $urandom % 3072, 2 + $urandom % 5);
    // stalled channel with a live request must not start
    cfg(3, 2 | (1 << CTL_STALL), 2);
    apb(1, ADDR_ENABLES, 8);
    function_select_req <= 7'h08;
    repeat (20) @(posedge pclk);
    chk(far.glog.size(), 0);
    apb(1, ADDR_ENABLES, 0);
    apb(1, ADDR_CONTROL, 2);
    repeat (20) @(posedge pclk);
    chk(far.glog.size(), 0);
    function_select_req <= 7'h00;
    apb(1, ADDR_ENABLES, 8);
    apb(1, ADDR_ACTIVITY, 8);
    wait_flag(3, 0);
    chk(half_flags[3], 1);
    $display("test stall done");
    tally_and_finish;
  end
endmodule // scxd_byte_mover_tb
